// *** hw/eeprom_status_latch.v ***
`timescale 1ns/10ps
`include "eeprom_status_defs.vh"

// Function
// (R1) One eight-bit status register
// (R2) Bit 7 protect-pin enable, default zero
// (R3) Bits 6:4 read ones while writing
// (R4) Bits 3:2 block guard, default none
// (R5) Guard 10 half, 01 upper quarter
// (R6) Bit 1 write latch, zero at power-up
// (R7) Bit 0 busy flag while operating
// (R8) Opcode 05h then status shifted out
// (R9) Status resampled every eight bits
// (R10) Poll 08h returns FFh while busy
// (R11) Poll returns 00h when idle
// (R12) Poll byte refreshed every eight bits
// (R13) Opcode 06h sets latch at deselect
// (R14) Master sets latch before every write
// (R15) Opcode 04h clears the write latch
// (R16) Clear works regardless of protect pin
// (R17) MSB first, rise sample, fall drive
// (R18) While busy only reads are answered
// (R19) Finished write cycle clears the latch
// (R20) Output floats unless read opcode done
// (R21) Latch changes only on whole-byte deselect; write_cycle_done and reset also clear it
module eeprom_status_latch #(
  parameter [1:0] GUARD_RESET      = `GUARD_NONE,
  parameter       PROTECT_EN_RESET = 1'b0
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        chip_sel_n,
  input  wire        serial_clk,
  input  wire        serial_in,
  output reg         serial_out,
  output reg         serial_out_en_n,
  input  wire        write_cycle_busy,
  input  wire        write_cycle_done,
  input  wire [17:0] check_addr,
  output reg         addr_guarded,
  output reg         write_latch,
  output reg  [7:0]  device_status
);

  reg  [2:0] cs_sync;
  reg  [2:0] sck_sync;
  reg  [1:0] si_sync;
  reg  [1:0] phase;
  reg  [2:0] bit_cnt;
  reg  [7:0] shift_in;
  reg  [7:0] shift_out;
  reg        byte_full;
  reg  [7:0] opcode;
  reg        protect_pin_enable;
  reg  [1:0] block_guard;

  // Frame phases; every frame starts by collecting an opcode.
  localparam [1:0] ST_OPCODE = `PH_OPCODE;
  localparam [1:0] ST_STATUS = `PH_STATUS;
  localparam [1:0] ST_POLL   = `PH_POLL;
  localparam [1:0] ST_IGNORE = `PH_IGNORE;

  wire       cs_low   = ~cs_sync[1];
  wire       cs_rise  = cs_sync[1] & ~cs_sync[2];
  wire       sck_rise = sck_sync[1] & ~sck_sync[2];
  wire       sck_fall = ~sck_sync[1] & sck_sync[2];
  wire       si_bit   = si_sync[1];
  wire [7:0] next_in  = {shift_in[6:0], si_bit};
  wire [7:0] live_status;

  // Reserved bits mirror the write cycle rather than storing anything.
  assign live_status[`BIT_PROTECT_PIN_EN]         = protect_pin_enable; // R2
  assign live_status[`BIT_RES_HI:`BIT_RES_LO]     = write_cycle_busy ?
                                                    `RESERVED_ONES : `RESERVED_ZEROS; // R3
  assign live_status[`BIT_GUARD_HI:`BIT_GUARD_LO] = block_guard;        // R4
  assign live_status[`BIT_WRITE_LATCH]            = write_latch;        // R6
  assign live_status[`BIT_BUSY]                   = write_cycle_busy;   // R7

  function guarded;
    input [1:0]  guard;
    input [17:0] addr;
    begin
      case (guard)
        `GUARD_NONE:    guarded = 1'b0;
        `GUARD_QUARTER: guarded = (addr >= `ADDR_QUARTER_BASE); // R5
        `GUARD_HALF:    guarded = (addr >= `ADDR_HALF_BASE);    // R5
        `GUARD_ALL:     guarded = 1'b1;
        default:        guarded = 1'b1;
      endcase
    end
  endfunction

  function [7:0] poll_byte;
    input busy;
    begin
      poll_byte = busy ? `POLL_BUSY_BYTE : `POLL_IDLE_BYTE; // R10 R11
    end
  endfunction

  // Only the two read opcodes open a reply; all others wait for deselect.
  function [1:0] phase_for;
    input [7:0] op;
    begin
      case (op)
        `OP_STATUS_READ: phase_for = ST_STATUS; // R8
        `OP_WRITE_POLL:  phase_for = ST_POLL;   // R10
        default:         phase_for = ST_IGNORE;
      endcase
    end
  endfunction

  // The byte that a reply phase loads at the start of each output byte.
  function [7:0] reply_byte;
    input [1:0] ph;
    input [7:0] status;
    input       busy;
    begin
      case (ph)
        ST_STATUS: reply_byte = status;          // R8 R9
        ST_POLL:   reply_byte = poll_byte(busy); // R10 R11 R12
        default:   reply_byte = 8'h00;
      endcase
    end
  endfunction

  // Pins are foreign to ref_clk; the first stage feeds only the second.
  // Each serial clock level must last more than one ref_clk period, or an edge is missed.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_sync  <= 3'h7;
      sck_sync <= 3'h0;
      si_sync  <= 2'h0;
    end else begin
      cs_sync  <= {cs_sync[1:0], chip_sel_n};
      sck_sync <= {sck_sync[1:0], serial_clk};
      si_sync  <= {si_sync[0], serial_in};
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      phase           <= ST_OPCODE;
      bit_cnt         <= `BYTE_FIRST_BIT;
      shift_in        <= 8'h00;
      shift_out       <= 8'h00;
      byte_full       <= 1'b0;
      opcode          <= 8'h00;
      serial_out      <= 1'b0;
      serial_out_en_n <= 1'b1;
    end else if (!cs_low) begin
      phase           <= ST_OPCODE;        // R20
      bit_cnt         <= `BYTE_FIRST_BIT;
      byte_full       <= 1'b0;
      serial_out_en_n <= 1'b1;             // R20
    end else begin
      if (sck_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
      // Rising and falling edges never coincide, so one branch acts per edge.
      case (phase)
        ST_OPCODE: begin
          if (sck_rise) begin
            shift_in <= next_in;           // R17
          end
          if (sck_rise && bit_cnt == `BYTE_LAST_BIT) begin
            opcode    <= next_in;
            byte_full <= 1'b1;
            // A busy device answers only the two read opcodes.
            phase     <= phase_for(next_in); // R8 R18
            shift_out <= reply_byte(phase_for(next_in), live_status, write_cycle_busy);
          end
        end
        ST_STATUS, ST_POLL: begin
          if (sck_rise && bit_cnt == `BYTE_LAST_BIT) begin
            // Resample at each byte boundary so polling sees fresh state.
            shift_out <= reply_byte(phase, live_status, write_cycle_busy); // R9 R12
          end else if (sck_fall) begin
            serial_out      <= shift_out[7]; // R17
            shift_out       <= {shift_out[6:0], 1'b0};
            serial_out_en_n <= 1'b0;         // R20
          end
        end
        ST_IGNORE: begin
          if (sck_rise) begin
            byte_full <= 1'b0;             // R21
          end
        end
        default: begin
          phase <= ST_OPCODE;
        end
      endcase
    end
  end

  // Only a deselect right after exactly eight opcode bits acts on the latch.
  // A finished write cycle outranks a set-latch deselect in the same cycle.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      write_latch        <= 1'b0;               // R6
      protect_pin_enable <= PROTECT_EN_RESET;   // R2
      block_guard        <= GUARD_RESET;        // R4
    end else if (write_cycle_done) begin
      write_latch <= 1'b0;                      // R19
    end else if (cs_rise && byte_full && phase == ST_IGNORE && bit_cnt == `BYTE_FIRST_BIT
                 && !write_cycle_busy) begin    // R18 R21
      if (opcode == `OP_SET_WRITE_LATCH)
        write_latch <= 1'b1;                    // R13
      else if (opcode == `OP_CLEAR_WRITE_LATCH)
        write_latch <= 1'b0;                    // R15 R16
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      device_status <= 8'h00;
      addr_guarded  <= 1'b0;
    end else begin
      device_status <= live_status;             // R1
      addr_guarded  <= guarded(block_guard, check_addr); // R5
    end
  end

endmodule

// *** hw/eeprom_status_defs.vh ***
`ifndef EEPROM_STATUS_DEFS_VH
`define EEPROM_STATUS_DEFS_VH

`define OP_STATUS_READ       8'h05
`define OP_WRITE_POLL        8'h08
`define OP_SET_WRITE_LATCH   8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04

`define BIT_PROTECT_PIN_EN   7
`define BIT_RES_HI           6
`define BIT_RES_LO           4
`define BIT_GUARD_HI         3
`define BIT_GUARD_LO         2
`define BIT_WRITE_LATCH      1
`define BIT_BUSY             0

`define GUARD_NONE           2'h0
`define GUARD_QUARTER        2'h1
`define GUARD_HALF           2'h2
`define GUARD_ALL            2'h3

`define ADDR_QUARTER_BASE    18'h30000
`define ADDR_HALF_BASE       18'h20000

`define POLL_BUSY_BYTE       8'hff
`define POLL_IDLE_BYTE       8'h00
`define RESERVED_ONES        3'h7
`define RESERVED_ZEROS       3'h0

`define BYTE_LAST_BIT        3'h7
`define BYTE_FIRST_BIT       3'h0

`define PH_OPCODE            2'h0
`define PH_STATUS            2'h1
`define PH_POLL              2'h2
`define PH_IGNORE            2'h3

`endif

// *** test/eeprom_status_checker.sv ***
`timescale 1ns/10ps
module eeprom_status_checker #(
  parameter [1:0] GUARD_RESET      = 2'h0,
  parameter       PROTECT_EN_RESET = 1'b0
) (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        chip_sel_n,
  input wire        serial_clk,
  input wire        serial_in,
  input wire        serial_out,
  input wire        serial_out_en_n,
  input wire        write_cycle_busy,
  input wire        write_cycle_done,
  input wire [17:0] check_addr,
  input wire        addr_guarded,
  input wire        write_latch,
  input wire [7:0]  device_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_busy_copy: assert property (device_status[0] == $past(write_cycle_busy))
    else $error("busy bit wrong");
  a_reserved_track: assert property (device_status[6:4] == {3{device_status[0]}})
    else $error("reserved bits wrong");
  a_latch_copy: assert property (device_status[1] == $past(write_latch))
    else $error("latch bit wrong");
  a_status_fixed: assert property ($past(rst_n) |-> device_status[7] == PROTECT_EN_RESET
    && device_status[3:2] == GUARD_RESET) else $error("fixed bits wrong");
  a_done_clears: assert property (write_cycle_done |=> !write_latch)
    else $error("latch kept after done");
  a_float_desel: assert property (chip_sel_n [*5] |-> serial_out_en_n)
    else $error("output driven while deselected");
  a_drive_selected: assert property ($fell(serial_out_en_n) |-> !$past(chip_sel_n, 3))
    else $error("output driven without select");
  a_set_after_cs: assert property ($rose(write_latch) |-> $past(chip_sel_n, 2))
    else $error("latch set inside frame");
  a_guard_range: assert property ($past(rst_n) |-> addr_guarded == (GUARD_RESET == 2'h3
    || GUARD_RESET == 2'h2 && $past(check_addr) >= 18'h20000
    || GUARD_RESET == 2'h1 && $past(check_addr) >= 18'h30000)) else $error("guard wrong");
  cover property ($rose(write_latch));
  cover property ($fell(write_latch));
  cover property ($fell(serial_out_en_n));
endmodule

bind eeprom_status_latch eeprom_status_checker #(.GUARD_RESET(GUARD_RESET),
  .PROTECT_EN_RESET(PROTECT_EN_RESET)) u_chk (
  .ref_clk, .rst_n, .chip_sel_n, .serial_clk, .serial_in, .serial_out, .serial_out_en_n,
  .write_cycle_busy, .write_cycle_done, .check_addr, .addr_guarded, .write_latch,
  .device_status);

// *** test/spi_master_model.sv ***
`timescale 1ns/10ps
module spi_master_model (
  input  wire ref_clk,
  input  wire serial_out,
  input  wire serial_out_en_n,
  output reg  chip_sel_n = 1'b1,
  output reg  serial_clk = 1'b0,
  output reg  serial_in  = 1'b0
);
  reg  [7:0] sh = 8'h00;
  // A released line reads as the inverse of the last bit, so a float never mimics 00h or FFh.
  wire       so_line = serial_out_en_n ? ~sh[0] : serial_out;
  task automatic xfer(input [7:0] op, input integer nb, output [7:0] rd);
    integer i;
    begin
      chip_sel_n <= 1'b0;
      for (i = 0; i < 8 * (nb + 1); i = i + 1) begin
        serial_clk <= 1'b0;
        serial_in  <= (i < 8) ? op[7 - i] : ~serial_in;
        repeat (5) @(posedge ref_clk);
        if (i >= 8) sh = {sh[6:0], so_line};
        serial_clk <= 1'b1;
        repeat (3) @(posedge ref_clk);
      end
      rd = sh;
      serial_clk <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chip_sel_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
    end
  endtask
endmodule

// *** test/eeprom_status_and_write_latch_test.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module eeprom_status_and_write_latch_test;
  reg         ref_clk = 1'b0, rst_n = 1'b0, write_cycle_busy = 1'b0, write_cycle_done = 1'b0;
  reg  [17:0] check_addr = 18'h0;
  reg  [7:0]  rd;
  wire        cs_n, sck, si, so, so_en_n, addr_guarded, write_latch;
  wire [7:0]  device_status;
  integer     n_mismatch = 0, comparisons = 0;
  initial forever #10 ref_clk = ~ref_clk;
  eeprom_status_latch #(.GUARD_RESET(2'h1)) u_eeprom_status_latch (.ref_clk(ref_clk),
    .rst_n(rst_n), .chip_sel_n(cs_n), .serial_clk(sck), .serial_in(si), .serial_out(so),
    .serial_out_en_n(so_en_n), .write_cycle_busy(write_cycle_busy),
    .write_cycle_done(write_cycle_done), .check_addr(check_addr),
    .addr_guarded(addr_guarded), .write_latch(write_latch), .device_status(device_status));
  spi_master_model u_spi_master_model (.ref_clk(ref_clk), .serial_out(so),
    .serial_out_en_n(so_en_n), .chip_sel_n(cs_n), .serial_clk(sck), .serial_in(si));
  task rdchk(input [7:0] op, input integer nb, input [7:0] e);
    u_spi_master_model.xfer(op, nb, rd);
    `CHK("read byte", e, rd)
  endtask
  task results;
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK("status", 8'h04, device_status)
    rdchk(8'h05, 2, 8'h04);
    rdchk(8'h08, 2, 8'h00);
    u_spi_master_model.xfer(8'h06, 0, rd);
    `CHK("latch", 1'b1, write_latch)
    rdchk(8'h05, 1, 8'h06);
    u_spi_master_model.xfer(8'h04, 1, rd);
    `CHK("latch", 1'b1, write_latch)
    u_spi_master_model.xfer(8'h04, 0, rd);
    `CHK("latch", 1'b0, write_latch)
    fork
      rdchk(8'h08, 2, 8'hff);
      begin
        repeat (96) @(posedge ref_clk);
        write_cycle_busy <= 1'b1;
      end
    join
    rdchk(8'h05, 1, 8'h75);
    u_spi_master_model.xfer(8'h06, 0, rd);
    `CHK("latch", 1'b0, write_latch)
    fork
      rdchk(8'h05, 2, 8'h04);
      begin
        repeat (96) @(posedge ref_clk);
        write_cycle_busy <= 1'b0;
      end
    join
    u_spi_master_model.xfer(8'h06, 0, rd);
    `CHK("latch", 1'b1, write_latch)
    write_cycle_done <= 1'b1;
    @(posedge ref_clk) write_cycle_done <= 1'b0;
    @(posedge ref_clk);
    `CHK("latch", 1'b0, write_latch)
    check_addr <= 18'h2ffff;
    repeat (2) @(posedge ref_clk);
    `CHK("guard", 1'b0, addr_guarded)
    check_addr <= 18'h30000;
    repeat (2) @(posedge ref_clk);
    `CHK("guard", 1'b1, addr_guarded)
    u_spi_master_model.xfer(8'h06, 0, rd);
    `CHK("latch", 1'b1, write_latch)
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    `CHK("latch", 1'b0, write_latch)
    `CHK("status", 8'h04, device_status)
    results;
  end
endmodule
